// ---- src/apms_device.sv ----
// converter power sequencer: power modes, power-on calibration,
// wake on conversion start and conversion timing on the master clock
// assumes all link inputs are synchronous to CORE_CLK
//
// Behaviour
// R1 - power state from mode bits and pin
// R2 - full power-down turns off everything
// R3 - partial power-down keeps reference on
// R4 - mode bits reset to zero
// R5 - 00 with pin high: always powered
// R6 - 00 with pin low: down between conversions
// R7 - other modes ignore the pin
// R8 - host holds pin high for software control
// R9 - host holds pin low below 100 kSPS
// R10 - first start pulse runs 35 ms calibration
// R11 - no power-down until calibration finishes
// R12 - early register write cancels calibration
// R13 - host waits 300 us after cancel
// R14 - wake from power-down in 5 us
// R15 - power down when busy falls
// R16 - start falling edge wakes, ready 5 us
// R17 - host holds start low 5 us
// R18 - host may power up by write
// R19 - start by pin pulse or start bit
// R20 - conversion lasts 18.5 master clocks
// R21 - busy low on completion
// R22 - mode field decoding 01, 10, 11
// R23 - wake timer holds off conversion start
`timescale 1ns/1ns
module apms_device
    import apms_pkg::*;
#(
    parameter int CAL_CYCLES = CAL_CYC  // power-on timeout and calibration
)
(
    input  wire logic CORE_CLK,
    input  wire logic RESET,
    apms_if.dev       LINK,
    output logic      CORE_POWERED,
    output logic      REF_POWERED,
    output logic      CAL_ACTIVE,
    output logic      WAKING
);

    // ****************************************************************
    // state
    // ****************************************************************
    apms_state_t      state_ff;      // sequencer state
    apms_state_t      nxt_state;
    logic             pm_hi_ff;      // pwr_mgmt_hi
    logic             pm_lo_ff;      // pwr_mgmt_lo
    logic             nxt_pm_hi;
    logic             nxt_pm_lo;
    logic             cs_prev_ff;    // last conv_start_n
    logic             mck_prev_ff;   // last master clock level
    logic             pend_ff;       // start waiting for wake
    logic             nxt_pend;
    logic [5:0]       halves_ff;     // master clock half periods
    logic [5:0]       nxt_halves;
    logic             busy_ff;
    logic             core_ff;
    logic             ref_ff;
    logic             cal_ff;
    logic             wake_ff;
    logic             nxt_busy;
    logic             nxt_core;
    logic             nxt_ref;
    logic             nxt_cal;
    logic             nxt_wake;

    // helpers
    logic             cs_fall;       // conv_start_n falling edge
    logic             cs_rise;       // conv_start_n rising edge
    logic             mck_fall;      // master clock falling edge
    logic             mck_edge;      // any master clock edge
    logic             sw_start;      // write with start bit set
    logic             eff_hi;        // mode bits after this write
    logic             eff_lo;
    apms_pm_t         mode;          // current power mode
    logic             tmr_load;
    logic [TMR_W-1:0] tmr_val;
    logic             tmr_done;

    // ****************************************************************
    // edge detection and mode
    // ****************************************************************
    always_comb
    begin
        cs_fall  = cs_prev_ff && !LINK.conv_start_n;
        cs_rise  = !cs_prev_ff && LINK.conv_start_n;
        mck_fall = mck_prev_ff && !LINK.master_clk_in;
        mck_edge = mck_prev_ff ^ LINK.master_clk_in;
        sw_start = LINK.reg_wr && LINK.reg_wdata[CTL_GO_BIT];  // [R19]
        eff_hi   = LINK.reg_wr ? LINK.reg_wdata[CTL_HI_BIT] : pm_hi_ff;
        eff_lo   = LINK.reg_wr ? LINK.reg_wdata[CTL_LO_BIT] : pm_lo_ff;
        mode     = apms_decode(eff_hi, eff_lo,
                               LINK.low_power_enable_n);       // [R1]
    end

    // mode bits follow every control write
    always_comb
    begin
        nxt_pm_hi = eff_hi;
        nxt_pm_lo = eff_lo;
    end

    // ****************************************************************
    // sequencer next state
    // ****************************************************************
    always_comb
    begin
        nxt_state  = state_ff;
        nxt_pend   = pend_ff;
        nxt_halves = halves_ff;
        tmr_load   = 1'b0;
        tmr_val    = TMR_W'(WAKE_CYC);
        case (state_ff)
            ST_UNCAL:
            begin
                // waiting for the first start pulse after power-on
                if (sw_start)
                    nxt_state = ST_HOLD;                       // [R12]
                else if (LINK.reg_wr)
                    nxt_state = ST_IDLE;                       // [R12]
                else if (cs_rise)
                begin
                    nxt_state = ST_CAL;                        // [R10]
                    tmr_load  = 1'b1;
                    tmr_val   = TMR_W'(CAL_CYCLES);
                end
            end
            ST_CAL:
            begin
                // pin and modes are not looked at here
                if (tmr_done)
                    nxt_state = ST_IDLE;                       // [R11]
            end
            ST_IDLE:
            begin
                if (cs_rise || sw_start)
                    nxt_state = ST_HOLD;                       // [R19]
                else if (mode == PM_FULL_DOWN)
                    nxt_state = ST_DOWN;                       // [R2]
                // full-up mode never leaves the powered states [R5]
            end
            ST_HOLD:
            begin
                // conversion begins on the next mclk falling edge
                if (mck_fall)
                begin
                    nxt_state  = ST_CONV;                      // [R20]
                    nxt_halves = '0;
                end
            end
            ST_CONV:
            begin
                if (mck_edge)
                    nxt_halves = halves_ff + 1'b1;             // [R20]
                if (mck_edge && halves_ff == CONV_HALVES - 1'b1)
                begin
                    // busy falls here; between-conversion modes sleep
                    if (mode == PM_PDBC_FULL || mode == PM_PDBC_PART)
                        nxt_state = ST_DOWN;                   // [R15]
                    else
                        nxt_state = ST_IDLE;                   // [R21]
                end
            end
            ST_DOWN:
            begin
                nxt_pend = sw_start;
                if (cs_fall)
                begin
                    nxt_state = ST_WAKE;                       // [R16]
                    tmr_load  = 1'b1;
                end
                else if (LINK.reg_wr && mode != PM_FULL_DOWN)
                begin
                    nxt_state = ST_WAKE;                       // [R14]
                    tmr_load  = 1'b1;
                end
            end
            ST_WAKE:
            begin
                // starts seen while waking are held until ready
                if (cs_rise || sw_start)
                    nxt_pend = 1'b1;                           // [R23]
                if (tmr_done)
                begin
                    nxt_state = (pend_ff || cs_rise || sw_start)
                              ? ST_HOLD : ST_IDLE;             // [R23]
                    nxt_pend  = 1'b0;
                end
            end
            default:
            begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // ****************************************************************
    // outputs from the next state
    // ****************************************************************
    always_comb
    begin
        nxt_busy = (nxt_state == ST_HOLD) || (nxt_state == ST_CONV);
        nxt_core = (nxt_state != ST_DOWN);                     // [R2]
        nxt_ref  = (nxt_state != ST_DOWN) ||
                   (apms_decode(nxt_pm_hi, nxt_pm_lo,
                    LINK.low_power_enable_n) == PM_PDBC_PART); // [R3]
        nxt_cal  = (nxt_state == ST_CAL);
        nxt_wake = (nxt_state == ST_WAKE);
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge CORE_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            state_ff    <= ST_UNCAL;
            pm_hi_ff    <= 1'b0;                               // [R4]
            pm_lo_ff    <= 1'b0;                               // [R4]
            cs_prev_ff  <= 1'b1;
            mck_prev_ff <= 1'b0;
            pend_ff     <= 1'b0;
            halves_ff   <= '0;
            busy_ff     <= 1'b0;
            core_ff     <= 1'b1;
            ref_ff      <= 1'b1;
            cal_ff      <= 1'b0;
            wake_ff     <= 1'b0;
        end
        else
        begin
            state_ff    <= nxt_state;
            pm_hi_ff    <= nxt_pm_hi;
            pm_lo_ff    <= nxt_pm_lo;
            cs_prev_ff  <= LINK.conv_start_n;
            mck_prev_ff <= LINK.master_clk_in;
            pend_ff     <= nxt_pend;
            halves_ff   <= nxt_halves;
            busy_ff     <= nxt_busy;
            core_ff     <= nxt_core;
            ref_ff      <= nxt_ref;
            cal_ff      <= nxt_cal;
            wake_ff     <= nxt_wake;
        end
    end

    // ****************************************************************
    // calibration and wake timer
    // ****************************************************************
    apms_timer u_timer
    (
        .clk   (CORE_CLK),
        .rst   (RESET),
        .load  (tmr_load),
        .value (tmr_val),
        .done  (tmr_done)
    );

    assign LINK.busy    = busy_ff;
    assign CORE_POWERED = core_ff;
    assign REF_POWERED  = ref_ff;
    assign CAL_ACTIVE   = cal_ff;
    assign WAKING       = wake_ff;
endmodule

// ---- src/apms_pkg.sv ----
// shared constants, types and mode decoding for the power sequencer
// assumes a 250 MHz core clock; both ends import this package whole
package apms_pkg;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_NS     = 4;          // core clock period
    localparam int WAKE_NS    = 5000;       // wake from power-down
    localparam int WAKE_CYC   = (WAKE_NS + CLK_NS - 1) / CLK_NS;
    localparam int CAL_NS     = 35000000;   // timeout plus calibration
    localparam int CAL_CYC    = CAL_NS / CLK_NS;
    localparam int SETTLE_NS  = 300000;     // wait after cancelled cal
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [5:0] CONV_HALVES   = 6'h25; // 18.5 mclk periods
    localparam logic [4:0] MCLK_HALF_CYC = 5'h14; // mclk half period
    localparam int TMR_W      = 24;         // timer width

    // ****************************************************************
    // host register map and fields
    // ****************************************************************
    localparam logic [31:0] CTRL_OFS = 32'h0000_0000;
    localparam logic [31:0] CMD_OFS  = 32'h0000_0004;
    localparam logic [31:0] STAT_OFS = 32'h0000_0008;
    localparam int CTL_LO_BIT   = 0;        // pwr_mgmt_lo
    localparam int CTL_HI_BIT   = 1;        // pwr_mgmt_hi
    localparam int CTL_GO_BIT   = 2;        // conversion start
    localparam int CTL_LPEN_BIT = 3;        // low_power_enable_n level
    localparam logic [3:0] CTRL_RST = 4'h8;
    localparam int CMD_PULSE_BIT = 0;       // pulse conv_start_n
    localparam int ST_BUSY_BIT   = 0;
    localparam int ST_PULSE_BIT  = 1;
    localparam int ST_SETTLE_BIT = 2;
    localparam int ST_DONE_BIT   = 3;
    localparam int LW_W = 3;                // link register word width

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [3:0] {
        PM_FULL_UP   = 4'h1,
        PM_PDBC_FULL = 4'h2,
        PM_FULL_DOWN = 4'h4,
        PM_PDBC_PART = 4'h8
    } apms_pm_t;

    typedef enum logic [6:0] {
        ST_UNCAL = 7'h01,
        ST_CAL   = 7'h02,
        ST_IDLE  = 7'h04,
        ST_HOLD  = 7'h08,
        ST_CONV  = 7'h10,
        ST_DOWN  = 7'h20,
        ST_WAKE  = 7'h40
    } apms_state_t;

    // power mode from the two bits and the active-low pin
    function automatic apms_pm_t apms_decode(input logic hi,
                                             input logic lo,
                                             input logic lpen_n);
        apms_pm_t m;
        m = PM_FULL_UP;
        if (hi && lo)
            m = PM_PDBC_PART;              // [R22] [R7]
        else if (hi)
            m = PM_FULL_DOWN;              // [R22] [R7]
        else if (lo)
            m = PM_PDBC_FULL;              // [R22] [R7]
        else if (!lpen_n)
            m = PM_PDBC_FULL;              // [R6] [R1]
        else
            m = PM_FULL_UP;                // [R5] [R1]
        return m;
    endfunction

endpackage

// ---- src/apms_if.sv ----
// link between the host controller and the converter power sequencer
// all signals change on the shared core clock
`timescale 1ns/1ns
interface apms_if;
    logic            conv_start_n;       // conversion start, active low
    logic            low_power_enable_n; // power-down pin, active low
    logic            master_clk_in;      // converter master clock
    logic            reg_wr;             // control register write
    logic [2:0]      reg_wdata;          // {go, hi, lo}
    logic            busy;               // conversion in progress

    modport dev  (input  conv_start_n, low_power_enable_n,
                         master_clk_in, reg_wr, reg_wdata,
                  output busy);
    modport host (output conv_start_n, low_power_enable_n,
                         master_clk_in, reg_wr, reg_wdata,
                  input  busy);
endinterface

// ---- src/apms_timer.sv ----
// loadable down counter used for calibration and wake intervals
// load wins over counting; done is high while the count is zero and load is low
`timescale 1ns/1ns
module apms_timer
    import apms_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             load,
    input  wire logic [TMR_W-1:0] value,
    output logic                  done
);
    logic [TMR_W-1:0] count_ff;      // remaining cycles
    logic [TMR_W-1:0] nxt_count;

    // ****************************************************************
    // next count
    // ****************************************************************
    always_comb
    begin
        nxt_count = count_ff;
        if (load)
            nxt_count = value;
        else if (count_ff != '0)
            nxt_count = count_ff - 1'b1;
    end

    // register the count
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            count_ff <= '0;
        else
            count_ff <= nxt_count;
    end

    assign done = (count_ff == '0) && !load;
endmodule

// ---- src/apms_host.sv ----
// host controller: AHB-Lite register slave that drives the link
// pins, generates the master clock and paces conversion pulses
`timescale 1ns/1ns
module apms_host
    import apms_pkg::*;
#(
    parameter int SETTLE_CYCLES = SETTLE_CYC  // wait after cancel
)
(
    input  wire logic        CORE_CLK,
    input  wire logic        RESET,
    apms_if.host             LINK,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic             HREADYOUT,
    output logic [31:0]      HRDATA,
    output logic             HRESP
);

    // ****************************************************************
    // state
    // ****************************************************************
    logic [3:0]  ctrl_ff;        // {lpen_n, go, hi, lo}
    logic [3:0]  nxt_ctrl;
    logic [2:0]  sel_ff;         // data phase write select, one-hot
    logic [2:0]  nxt_sel;
    logic [31:0] rdata_ff;       // read data for the data phase
    logic [31:0] nxt_rdata;
    logic [10:0] pulse_ff;       // low cycles left on conv_start_n
    logic [10:0] nxt_pulse;
    logic [16:0] settle_ff;      // settle cycles left
    logic [16:0] nxt_settle;
    logic        pulsed_ff;      // a start pulse went out since reset
    logic        nxt_pulsed;
    logic        wr_ff;
    logic        nxt_wr;
    logic [2:0]  wdata_ff;
    logic [2:0]  nxt_wdata;
    logic        done_ff;        // sticky conversion done
    logic        nxt_done;
    logic        busy_prev_ff;
    logic [4:0]  div_ff;         // master clock divider
    logic [4:0]  nxt_div;
    logic        mclk_ff;
    logic        nxt_mclk;
    logic        ap_ok;          // address phase accepted
    logic [31:0] status;

    // ****************************************************************
    // bus decode and register update
    // ****************************************************************
    always_comb
    begin
        ap_ok      = HSEL && HTRANS[1] && HREADY;
        status     = '0;
        status[ST_BUSY_BIT]   = LINK.busy;
        status[ST_PULSE_BIT]  = (pulse_ff != '0);
        status[ST_SETTLE_BIT] = (settle_ff != '0);
        status[ST_DONE_BIT]   = done_ff;
        nxt_sel    = '0;
        nxt_rdata  = rdata_ff;
        if (ap_ok)
        begin
            nxt_rdata = '0;
            if (HADDR == CTRL_OFS)
            begin
                nxt_sel[0] = HWRITE;
                nxt_rdata  = {28'h0000000, ctrl_ff};
            end
            else if (HADDR == CMD_OFS)
                nxt_sel[1] = HWRITE;
            else if (HADDR == STAT_OFS)
            begin
                nxt_sel[2] = HWRITE;
                nxt_rdata  = status;
            end
        end
        nxt_ctrl   = ctrl_ff;
        nxt_wr     = 1'b0;
        nxt_wdata  = wdata_ff;
        nxt_pulse  = (pulse_ff != '0) ? pulse_ff - 1'b1 : pulse_ff;
        nxt_settle = (settle_ff != '0) ? settle_ff - 1'b1 : settle_ff;
        nxt_pulsed = pulsed_ff;
        // set wins over the clear
        nxt_done   = done_ff || (busy_prev_ff && !LINK.busy);
        if (sel_ff[0])
        begin
            // go bit is passed on but not kept
            nxt_ctrl  = HWDATA[3:0] & 4'hb;
            nxt_wr    = 1'b1;                                  // [R18]
            nxt_wdata = HWDATA[LW_W-1:0];
            if (!pulsed_ff)
                nxt_settle = 17'(SETTLE_CYCLES);               // [R13]
        end
        if (sel_ff[1] && HWDATA[CMD_PULSE_BIT] && pulse_ff == '0)
        begin
            nxt_pulse  = 11'(WAKE_CYC);                        // [R17]
            nxt_pulsed = 1'b1;
        end
        if (sel_ff[2] && HWDATA[ST_DONE_BIT] &&
            !(busy_prev_ff && !LINK.busy))
            nxt_done = 1'b0;
    end

    // master clock divider
    always_comb
    begin
        nxt_div  = div_ff + 1'b1;
        nxt_mclk = mclk_ff;
        if (div_ff == MCLK_HALF_CYC - 1'b1)
        begin
            nxt_div  = '0;
            nxt_mclk = !mclk_ff;
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge CORE_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            ctrl_ff      <= CTRL_RST;                          // [R8]
            sel_ff       <= '0;
            rdata_ff     <= '0;
            pulse_ff     <= '0;
            settle_ff    <= '0;
            pulsed_ff    <= 1'b0;
            wr_ff        <= 1'b0;
            wdata_ff     <= '0;
            done_ff      <= 1'b0;
            busy_prev_ff <= 1'b0;
            div_ff       <= '0;
            mclk_ff      <= 1'b0;
        end
        else
        begin
            ctrl_ff      <= nxt_ctrl;
            sel_ff       <= nxt_sel;
            rdata_ff     <= nxt_rdata;
            pulse_ff     <= nxt_pulse;
            settle_ff    <= nxt_settle;
            pulsed_ff    <= nxt_pulsed;
            wr_ff        <= nxt_wr;
            wdata_ff     <= nxt_wdata;
            done_ff      <= nxt_done;
            busy_prev_ff <= LINK.busy;
            div_ff       <= nxt_div;
            mclk_ff      <= nxt_mclk;
        end
    end

    // pin level set by software, low for sleep at low rates [R9]
    assign LINK.low_power_enable_n = ctrl_ff[CTL_LPEN_BIT];
    assign LINK.conv_start_n       = (pulse_ff == '0);     // [R17]
    assign LINK.master_clk_in      = mclk_ff;
    assign LINK.reg_wr             = wr_ff;
    assign LINK.reg_wdata          = wdata_ff;
    assign HREADYOUT = 1'b1;
    assign HRDATA    = rdata_ff;
    assign HRESP     = 1'b0;
endmodule

// ---- testbench/apms_assertions.sv ----
// checker on the link and the device power outputs
// assumes the bench wires it beside the link, one core clock
`timescale 1ns/1ns
module apms_assertions
(
    input wire logic CORE_CLK,
    input wire logic RESET,
    input wire logic conv_start_n,
    input wire logic busy,
    input wire logic CORE_POWERED,
    input wire logic REF_POWERED,
    input wire logic CAL_ACTIVE,
    input wire logic WAKING
);
    int bcnt_ff, nxt_bcnt; // cycles with busy high
    int lcnt_ff, nxt_lcnt; // cycles with conv_start_n low
    always_comb nxt_bcnt = busy ? bcnt_ff + 1 : 0;
    always_comb nxt_lcnt = conv_start_n ? 0 : lcnt_ff + 1;
    // busy and start pulse length counters, cleared while idle
    always_ff @(posedge CORE_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            bcnt_ff <= 0;
            lcnt_ff <= 0;
        end
        else
        begin
            bcnt_ff <= nxt_bcnt;
            lcnt_ff <= nxt_lcnt;
        end
    end
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RESET);
    ref_off_a: assert property (!REF_POWERED |-> !CORE_POWERED)
        else $error("core on with reference off");
    cal_up_a: assert property
        (CAL_ACTIVE |-> CORE_POWERED && !busy)
        else $error("power-down or busy in calibration");
    cal_len_a: assert property
        ($rose(CAL_ACTIVE) |=> CAL_ACTIVE[*8])
        else $error("calibration cut short");
    wake_start_a: assert property
        ($fell(conv_start_n) && !CORE_POWERED |-> ##[1:2] WAKING)
        else $error("start edge did not wake");
    wake_len_a: assert property ($rose(WAKING) |=> WAKING[*8])
        else $error("wake interval cut short");
    wake_hold_a: assert property (WAKING |-> !busy)
        else $error("conversion during wake");
    busy_pwr_a: assert property
        (busy |-> CORE_POWERED && REF_POWERED)
        else $error("conversion while powered down");
    conv_len_a: assert property
        ($fell(busy) |-> bcnt_ff inside {[735:790]})
        else $error("conversion length wrong");
    // 1250 core cycles is the 5 us wake interval at 4 ns
    pulse_len_a: assert property
        ($rose(conv_start_n) |-> lcnt_ff >= 1250)
        else $error("start pulse shorter than wake time");
endmodule

// ---- testbench/apms_tb_top.sv ----
// bench: host and device joined by the link, host on AHB-Lite
// assumes the src/ package, link and modules are compiled first
`timescale 1ns/1ns
module apms_tb_top;
    import apms_pkg::*;
    logic        clk = 0, rst = 1, hsel = 1, hwrite = 0;
    logic [1:0]  htrans = 0;
    logic [2:0]  m; // {pin, hi, lo}
    logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
    logic        hrdy, core, refp, cal, wake;
    int          n_mismatch = 0, compares = 0;
    apms_if link ();
    apms_device #(.CAL_CYCLES(50)) apms_device_i (.CORE_CLK(clk),
        .RESET(rst), .LINK(link), .CORE_POWERED(core),
        .REF_POWERED(refp), .CAL_ACTIVE(cal), .WAKING(wake));
    apms_host #(.SETTLE_CYCLES(40)) apms_host_i (.CORE_CLK(clk),
        .RESET(rst), .LINK(link), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
        .HREADY(hrdy), .HREADYOUT(hrdy), .HRDATA(hrdata), .HRESP());
    apms_assertions apms_assertions_i (.CORE_CLK(clk), .RESET(rst),
        .conv_start_n(link.conv_start_n), .busy(link.busy),
        .CORE_POWERED(core), .REF_POWERED(refp), .CAL_ACTIVE(cal),
        .WAKING(wake));
    initial forever #2 clk = ~clk;
    // compare and count
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("ERROR %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // one single-word transfer; r takes the read data
    task automatic ahb(input logic [31:0] a, input logic w,
                       input logic [31:0] d);
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk); while (hrdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hrdy !== 1'b1);
        r = hrdata;
    endtask
    // bounded wait for busy to reach a level
    task automatic wb(input logic v);
        for (int i = 0; i < 4000 && link.busy !== v; i++)
            @(posedge clk);
        chk(32'(link.busy), 32'(v));
    endtask
    // {core, ref} expected after a conversion in mode m
    function automatic logic [1:0] exp_pwr(input logic [2:0] md);
        return (md == 3'h4) ? 2'h3 : (md[1:0] == 2'h3) ? 2'h1 : 2'h0;
    endfunction
    task automatic test_done;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // watchdog against a hang
    initial
    begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        test_done;
    end
    initial
    begin
        void'($urandom(34506));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        ahb(CTRL_OFS, 1'b0, 32'h0);
        chk(r, 32'(CTRL_RST));
        ahb(32'h10, 1'b0, 32'h0);
        chk(r, 32'h0);
        // first start pulse runs calibration; pin low then ignored
        ahb(CMD_OFS, 1'b1, 32'h1);
        repeat (1260) @(posedge clk);
        ahb(CTRL_OFS, 1'b1, 32'h0);
        repeat (3) @(posedge clk);
        chk(32'({cal, core}), 32'h3);
        repeat (60) @(posedge clk);
        $display("test calibration done");
        // five settings covering all four power modes, then random ones
        for (int k = 0; k < 8; k++)
        begin
            m = (k < 5) ? 3'(k * 3) : 3'($urandom);
            ahb(CTRL_OFS, 1'b1, {28'h0, m[2], 1'b0, m[1:0]});
            if (m[1:0] != 2'h2)
            begin
                ahb(k[0] ? CMD_OFS : CTRL_OFS, 1'b1,
                    k[0] ? 32'h1 : {28'h0, m[2], 1'b1, m[1:0]});
                wb(1'b1);
                wb(1'b0);
            end
            repeat (5) @(posedge clk);
            chk(32'({core, refp}), 32'(exp_pwr(m)));
            $display("test mode %h done", m);
        end
        // pin edge alone wakes a sleeping device
        ahb(CTRL_OFS, 1'b1, 32'h1);
        ahb(CMD_OFS, 1'b1, 32'h1);
        wb(1'b1);
        wb(1'b0);
        repeat (5) @(posedge clk);
        ahb(CMD_OFS, 1'b1, 32'h1);
        repeat (3) @(posedge clk);
        chk(32'({wake, core}), 32'h3);
        wb(1'b1);
        wb(1'b0);
        ahb(STAT_OFS, 1'b0, 32'h0);
        chk(32'(r[ST_DONE_BIT]), 32'h1);
        ahb(STAT_OFS, 1'b1, 32'h8);
        ahb(STAT_OFS, 1'b0, 32'h0);
        chk(32'(r[ST_DONE_BIT]), 32'h0);
        $display("test pin wake done");
        // early register write cancels calibration
        rst <= 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        ahb(CTRL_OFS, 1'b1, 32'h8);
        ahb(STAT_OFS, 1'b0, 32'h0);
        chk(32'(r[ST_SETTLE_BIT]), 32'h1);
        repeat (50) @(posedge clk);
        ahb(STAT_OFS, 1'b0, 32'h0);
        chk(32'(r[ST_SETTLE_BIT]), 32'h0);
        ahb(CMD_OFS, 1'b1, 32'h1);
        wb(1'b1);
        chk(32'(cal), 32'h0);
        $display("test cancel done");
        test_done;
    end
endmodule
